// ==== inc/qsp_defs.svh ====
// Constants of the quad asynchronous serial port block
`ifndef QSP_DEFS_SVH
`define QSP_DEFS_SVH

`define QSP_CLK_HZ      100000000
`define QSP_BAUD_MIN    300
`define QSP_BAUD_MAX    600000
`define QSP_DIV_W       20
`define QSP_DIV_MIN     20'((`QSP_CLK_HZ + `QSP_BAUD_MAX - 1) / `QSP_BAUD_MAX)
`define QSP_DIV_MAX     20'(`QSP_CLK_HZ / `QSP_BAUD_MIN)
`define QSP_LAST_BIT    3'h7
`define QSP_LINE_IDLE   1'b1
`define QSP_START_LEVEL 1'b0
`define QSP_STOP_LEVEL  1'b1
`define QSP_GPIO_N      16
`define QSP_SEL_W       4
`define QSP_TX_PIN_MASK 16'h33fa
`define QSP_RX_PIN_MASK 16'h3fff
`define QSP_BUF_DEPTH   4
`define QSP_PTR_W       2
`define QSP_LVL_W       3
`define QSP_BUF_FULL    3'h4

`endif

// ==== inc/qsp_pkg.sv ====
// Types shared by the quad asynchronous serial port block
package qsp_pkg;

    // One byte offered to a transmitter
    typedef struct packed {
        logic       valid;
        logic [7:0] data;
    } qsp_byte_t;

    // One received character with its outcome pulses
    typedef struct packed {
        logic [7:0] data;
        logic       valid;
        logic       ferr;
    } qsp_rx_t;

    // Frame phases, shared by transmitter and receiver
    typedef enum logic [3:0] {
        QSP_IDLE  = 4'b0001,
        QSP_START = 4'b0010,
        QSP_DATA  = 4'b0100,
        QSP_STOP  = 4'b1000
    } qsp_state_t;

endpackage : qsp_pkg

// ==== logic/qsp_tx.sv ====
// Serial transmitter: one start bit, eight data bits LSB first, one stop bit
`timescale 1ns/1ps
`include "qsp_defs.svh"

module qsp_tx (
    input  wire logic                  i_clk,
    input  wire logic                  i_rst_n,
    input  wire logic [`QSP_DIV_W-1:0] i_div,
    input  wire qsp_pkg::qsp_byte_t    i_req,
    output wire logic                  o_ready,
    output logic                       o_line
);

    qsp_pkg::qsp_state_t   state;   // Frame phase
    logic [`QSP_DIV_W-1:0] div_q;   // Divisor frozen for the frame
    logic [`QSP_DIV_W-1:0] cnt;     // Clocks spent in the current bit
    logic [2:0]            bitn;    // Data bit index
    logic [7:0]            shreg;   // Bits still to send

    wire bit_end = (cnt == div_q - 20'h1);

    // Accept only between frames, so a new byte never cuts a frame
    assign o_ready = (state == qsp_pkg::QSP_IDLE);

    // Bit sequencer
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            state <= qsp_pkg::QSP_IDLE;
            o_line <= `QSP_LINE_IDLE;
            div_q <= `QSP_DIV_MIN;
            cnt <= 20'h0;
            bitn <= 3'h0;
            shreg <= 8'h0;
        end else begin
            cnt <= bit_end ? 20'h0 : cnt + 20'h1;
            case (state)
                qsp_pkg::QSP_IDLE: begin
                    cnt <= 20'h0;
                    o_line <= `QSP_LINE_IDLE;
                    if (i_req.valid) begin
                        shreg <= i_req.data;
                        div_q <= i_div;
                        o_line <= `QSP_START_LEVEL;
                        state <= qsp_pkg::QSP_START;
                    end
                end
                qsp_pkg::QSP_START: begin
                    if (bit_end) begin
                        o_line <= shreg[0];
                        bitn <= 3'h0;
                        state <= qsp_pkg::QSP_DATA;
                    end
                end
                qsp_pkg::QSP_DATA: begin
                    if (bit_end) begin
                        if (bitn == `QSP_LAST_BIT) begin
                            o_line <= `QSP_STOP_LEVEL;
                            state <= qsp_pkg::QSP_STOP;
                        end else begin
                            o_line <= shreg[1];
                            shreg <= {1'b0, shreg[7:1]};
                            bitn <= bitn + 3'h1;
                        end
                    end
                end
                qsp_pkg::QSP_STOP: begin
                    if (bit_end) begin
                        state <= qsp_pkg::QSP_IDLE;
                    end
                end
                default: begin
                    state <= qsp_pkg::QSP_IDLE;
                    o_line <= `QSP_LINE_IDLE;
                end
            endcase
        end
    end

endmodule : qsp_tx

// ==== logic/qsp_rx.sv ====
// Serial receiver: start edge, midpoint sampling, stop check
`timescale 1ns/1ps
`include "qsp_defs.svh"

module qsp_rx (
    input  wire logic                  i_clk,
    input  wire logic                  i_rst_n,
    input  wire logic [`QSP_DIV_W-1:0] i_div,
    input  wire logic                  i_line,
    output qsp_pkg::qsp_rx_t           o_rx
);

    qsp_pkg::qsp_state_t   state;     // Frame phase
    logic [`QSP_DIV_W-1:0] div_q;     // Divisor frozen for the frame
    logic [`QSP_DIV_W-1:0] cnt;       // Clocks spent in the current bit
    logic [2:0]            bitn;      // Data bit index
    logic [7:0]            shreg;     // Bits gathered so far
    logic                  line_q;    // Line one clock ago

    // A held-low line must go high again before a new frame counts
    wire fall     = line_q & ~i_line;
    wire half_end = (cnt == {1'b0, div_q[`QSP_DIV_W-1:1]} - 20'h1);
    wire bit_end  = (cnt == div_q - 20'h1);

    // Frame sequencer
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            state <= qsp_pkg::QSP_IDLE;
            div_q <= `QSP_DIV_MIN;
            cnt <= 20'h0;
            bitn <= 3'h0;
            shreg <= 8'h0;
            line_q <= `QSP_LINE_IDLE;
            o_rx <= '0;
        end else begin
            line_q <= i_line;
            o_rx.valid <= 1'b0;
            o_rx.ferr <= 1'b0;
            cnt <= bit_end ? 20'h0 : cnt + 20'h1;
            case (state)
                qsp_pkg::QSP_IDLE: begin
                    cnt <= 20'h0;
                    if (fall) begin
                        div_q <= i_div;
                        state <= qsp_pkg::QSP_START;
                    end
                end
                qsp_pkg::QSP_START: begin
                    // Mid start bit: a glitch that is high again is dropped
                    if (half_end) begin
                        cnt <= 20'h0;
                        bitn <= 3'h0;
                        state <= (i_line == `QSP_START_LEVEL) ?
                                 qsp_pkg::QSP_DATA : qsp_pkg::QSP_IDLE;
                    end
                end
                qsp_pkg::QSP_DATA: begin
                    if (bit_end) begin
                        shreg <= {i_line, shreg[7:1]};
                        bitn <= bitn + 3'h1;
                        if (bitn == `QSP_LAST_BIT) begin
                            state <= qsp_pkg::QSP_STOP;
                        end
                    end
                end
                qsp_pkg::QSP_STOP: begin
                    if (bit_end) begin
                        if (i_line == `QSP_STOP_LEVEL) begin
                            o_rx.data <= shreg;
                            o_rx.valid <= 1'b1;
                        end else begin
                            o_rx.ferr <= 1'b1;
                        end
                        state <= qsp_pkg::QSP_IDLE;
                    end
                end
                default: begin
                    state <= qsp_pkg::QSP_IDLE;
                end
            endcase
        end
    end

endmodule : qsp_rx

// ==== logic/qsp_top.sv ====
// Four asynchronous serial ports: one on fixed pins, three mapped onto GPIO
`timescale 1ns/1ps
`include "qsp_defs.svh"

module qsp_top (
    input  wire logic                       I_MCLK,
    input  wire logic                       I_ARST_N,
    // Primary port pins, never remapped
    input  wire logic                       I_PRIMARY_SERIAL_IN,
    output wire logic                       O_PRIMARY_SERIAL_OUT,
    // General purpose pins shared by the secondary ports
    input  wire logic [`QSP_GPIO_N-1:0]     I_GPIO_IN,
    output wire logic [`QSP_GPIO_N-1:0]     O_GPIO_OUT,
    output wire logic [`QSP_GPIO_N-1:0]     O_GPIO_OE,
    // Pin choice of the three secondary ports, index 0 is port a
    input  wire logic [2:0][`QSP_SEL_W-1:0] I_TX_PIN_SEL,
    input  wire logic [2:0]                 I_TX_PIN_EN,
    input  wire logic [2:0][`QSP_SEL_W-1:0] I_RX_PIN_SEL,
    input  wire logic [2:0]                 I_RX_PIN_EN,
    // Loader side of the primary port
    input  wire logic                       I_PROG_RUN,
    input  wire qsp_pkg::qsp_byte_t         I_LDR_TX,
    output wire logic                       O_LDR_TX_READY,
    output qsp_pkg::qsp_rx_t                O_LDR_RX,
    // User side of all four ports, index 0 is the primary port
    input  wire logic [3:0][`QSP_DIV_W-1:0] I_BAUD_DIV,
    input  wire logic [3:0]                 I_BUF_MODE,
    input  wire qsp_pkg::qsp_byte_t [3:0]   I_TX_REQ,
    output wire logic [3:0]                 O_TX_READY,
    output qsp_pkg::qsp_rx_t [3:0]          O_RX,
    input  wire logic [3:0]                 I_RX_POP,
    output wire logic [3:0][7:0]            O_BUF_DATA,
    output wire logic [3:0]                 O_BUF_VALID,
    output wire logic [3:0][`QSP_LVL_W-1:0] O_BUF_LEVEL,
    output logic [3:0]                      O_OVERRUN,
    input  wire logic [3:0]                 I_OVR_CLR
);

    // Clamp a divisor into the supported baud range
    function automatic logic [`QSP_DIV_W-1:0] qsp_clamp_div(
        input logic [`QSP_DIV_W-1:0] d
    );
        if (d < `QSP_DIV_MIN) begin
            return `QSP_DIV_MIN;
        end else if (d > `QSP_DIV_MAX) begin
            return `QSP_DIV_MAX;
        end
        return d;
    endfunction : qsp_clamp_div

    // True when the chosen pin lies in the permitted set
    function automatic logic qsp_pin_ok(
        input logic [`QSP_GPIO_N-1:0] mask,
        input logic [`QSP_SEL_W-1:0]  sel
    );
        return mask[sel];
    endfunction : qsp_pin_ok

    logic [`QSP_GPIO_N-1:0] gpio_s1;    // First sync stage, read by gpio_s2 only
    logic [`QSP_GPIO_N-1:0] gpio_s2;    // Pin levels safe to use
    logic                   prim_s1;    // First sync stage of the primary input
    logic                   prim_s2;    // Primary input safe to use

    wire logic [3:0]        rx_line;    // Receive line of each port
    wire logic [3:0]        tx_line;    // Transmit line of each port
    wire logic [3:0]        tx_rdy;     // Transmitter idle
    qsp_pkg::qsp_byte_t     [3:0] tx_req;    // Request reaching each transmitter
    qsp_pkg::qsp_rx_t       [3:0] rx_evt;    // Receiver outcome pulses
    wire logic [2:0]        tx_map_ok;  // Secondary transmit mapped to a legal pin
    wire logic [2:0]        rx_map_ok;  // Secondary receive mapped to a legal pin

    // Pin synchronisers; the reset value is the idle line level
    always_ff @(posedge I_MCLK or negedge I_ARST_N) begin
        if (!I_ARST_N) begin
            gpio_s1 <= 16'hffff;
            gpio_s2 <= 16'hffff;
            prim_s1 <= `QSP_LINE_IDLE;
            prim_s2 <= `QSP_LINE_IDLE;
        end else begin
            gpio_s1 <= I_GPIO_IN;
            gpio_s2 <= gpio_s1;
            prim_s1 <= I_PRIMARY_SERIAL_IN;
            prim_s2 <= prim_s1;
        end
    end

    // Primary port stays on its own pins whatever the mapping says
    assign rx_line[0] = prim_s2;
    assign O_PRIMARY_SERIAL_OUT = tx_line[0];

    // Secondary mapping is honoured only for pins in the permitted set
    genvar k;
    generate
        for (k = 0; k < 3; k++) begin : g_map
            assign tx_map_ok[k] = I_TX_PIN_EN[k] &
                qsp_pin_ok(`QSP_TX_PIN_MASK, I_TX_PIN_SEL[k]);
            assign rx_map_ok[k] = I_RX_PIN_EN[k] &
                qsp_pin_ok(`QSP_RX_PIN_MASK, I_RX_PIN_SEL[k]);
            // Unmapped receiver sees an idle line, so it never frames noise
            assign rx_line[k+1] = rx_map_ok[k] ?
                gpio_s2[I_RX_PIN_SEL[k]] : `QSP_LINE_IDLE;
        end
    endgenerate

    // Pin drivers; two ports on one pin resolve to the lower port only
    genvar p;
    generate
        for (p = 0; p < `QSP_GPIO_N; p++) begin : g_pin
            wire logic [2:0] claim;    // Secondary transmitters on this pin
            assign claim[0] = tx_map_ok[0] && (I_TX_PIN_SEL[0] == 4'(p));
            assign claim[1] = tx_map_ok[1] && (I_TX_PIN_SEL[1] == 4'(p));
            assign claim[2] = tx_map_ok[2] && (I_TX_PIN_SEL[2] == 4'(p));
            assign O_GPIO_OE[p] = |claim;
            assign O_GPIO_OUT[p] = claim[0] ? tx_line[1] :
                                   claim[1] ? tx_line[2] :
                                   claim[2] ? tx_line[3] : `QSP_LINE_IDLE;
        end
    endgenerate

    // Until the program runs, the loader owns the primary transmitter
    assign tx_req[0] = I_PROG_RUN ? I_TX_REQ[0] : I_LDR_TX;
    assign O_LDR_TX_READY = ~I_PROG_RUN & tx_rdy[0];
    assign O_TX_READY[0] = I_PROG_RUN & tx_rdy[0];
    assign tx_req[3:1] = I_TX_REQ[3:1];
    assign O_TX_READY[3:1] = tx_rdy[3:1];

    // Loader copy of the primary receiver, silent once the program runs
    always_ff @(posedge I_MCLK or negedge I_ARST_N) begin
        if (!I_ARST_N) begin
            O_LDR_RX <= '0;
        end else begin
            O_LDR_RX.data <= rx_evt[0].data;
            O_LDR_RX.valid <= rx_evt[0].valid & ~I_PROG_RUN;
            O_LDR_RX.ferr <= rx_evt[0].ferr & ~I_PROG_RUN;
        end
    end

    // One transmitter and one receiver per port, each free running
    genvar n;
    generate
        for (n = 0; n < 4; n++) begin : g_port
            wire logic [`QSP_DIV_W-1:0] div;    // Divisor kept in range
            wire logic                  mine;   // Traffic belongs to the user
            wire logic                  push;   // Store a good byte
            wire logic                  take;   // Push that finds room
            wire logic                  pop;    // Release the oldest byte
            logic [7:0] mem [`QSP_BUF_DEPTH];   // Background receive store
            logic [`QSP_PTR_W-1:0]      wr;     // Write index
            logic [`QSP_PTR_W-1:0]      rd;     // Read index
            logic [`QSP_LVL_W-1:0]      lvl;    // Bytes held

            assign div = qsp_clamp_div(I_BAUD_DIV[n]);
            assign mine = (n != 0) || I_PROG_RUN;

            // Separate engines give full duplex at the port's own rate
            qsp_tx u_tx (
                .i_clk   (I_MCLK),
                .i_rst_n (I_ARST_N),
                .i_div   (div),
                .i_req   (tx_req[n]),
                .o_ready (tx_rdy[n]),
                .o_line  (tx_line[n])
            );

            qsp_rx u_rx (
                .i_clk   (I_MCLK),
                .i_rst_n (I_ARST_N),
                .i_div   (div),
                .i_line  (rx_line[n]),
                .o_rx    (rx_evt[n])
            );

            // Framing errors never reach the store, only good bytes do
            assign push = mine & I_BUF_MODE[n] & rx_evt[n].valid;
            assign pop = I_RX_POP[n] & (lvl != 3'h0);
            assign take = push & ((lvl != `QSP_BUF_FULL) | pop);
            assign O_BUF_DATA[n] = mem[rd];
            assign O_BUF_VALID[n] = (lvl != 3'h0);
            assign O_BUF_LEVEL[n] = lvl;

            // Single byte mode bytes and framing errors in any mode: each shown once, one clock later
            always_ff @(posedge I_MCLK or negedge I_ARST_N) begin
                if (!I_ARST_N) begin
                    O_RX[n] <= '0;
                end else begin
                    O_RX[n].data <= rx_evt[n].data;
                    O_RX[n].valid <= mine & ~I_BUF_MODE[n] &
                                     rx_evt[n].valid;
                    O_RX[n].ferr <= mine & rx_evt[n].ferr;
                end
            end

            // Full store keeps unread bytes; a pop makes room at once
            always_ff @(posedge I_MCLK or negedge I_ARST_N) begin
                if (!I_ARST_N) begin
                    wr <= 2'h0;
                    rd <= 2'h0;
                    lvl <= 3'h0;
                    for (int i = 0; i < `QSP_BUF_DEPTH; i++) begin
                        mem[i] <= 8'h0;
                    end
                end else begin
                    if (take) begin
                        mem[wr] <= rx_evt[n].data;
                        wr <= wr + 2'h1;
                    end
                    if (pop) begin
                        rd <= rd + 2'h1;
                    end
                    lvl <= lvl + 3'(take) - 3'(pop);
                end
            end

            // Overrun flag; a new loss in the clear cycle keeps it set
            always_ff @(posedge I_MCLK or negedge I_ARST_N) begin
                if (!I_ARST_N) begin
                    O_OVERRUN[n] <= 1'b0;
                end else if (push && (lvl == `QSP_BUF_FULL) && !pop) begin
                    O_OVERRUN[n] <= 1'b1;
                end else if (I_OVR_CLR[n]) begin
                    O_OVERRUN[n] <= 1'b0;
                end
            end
        end
    endgenerate

endmodule : qsp_top

// ==== tb/qsp_top_chk.sv ====
// Pin level checks on the quad serial port block
`timescale 1ns/1ps
`include "qsp_defs.svh"
module qsp_top_chk (
    input  wire logic                       I_MCLK,
    input  wire logic                       I_ARST_N,
    input  wire logic                       O_PRIMARY_SERIAL_OUT,
    input  wire logic [`QSP_GPIO_N-1:0]     O_GPIO_OUT,
    input  wire logic [`QSP_GPIO_N-1:0]     O_GPIO_OE,
    input  wire logic [2:0][`QSP_SEL_W-1:0] I_TX_PIN_SEL,
    input  wire logic                       I_PROG_RUN,
    input  wire qsp_pkg::qsp_byte_t         I_LDR_TX,
    input  wire logic                       O_LDR_TX_READY,
    input  wire qsp_pkg::qsp_rx_t           O_LDR_RX,
    input  wire logic [3:0][`QSP_DIV_W-1:0] I_BAUD_DIV,
    input  wire qsp_pkg::qsp_byte_t [3:0]   I_TX_REQ,
    input  wire logic [3:0]                 O_TX_READY,
    input  wire qsp_pkg::qsp_rx_t [3:0]     O_RX,
    input  wire logic [3:0][`QSP_LVL_W-1:0] O_BUF_LEVEL,
    input  wire logic [3:0]                 O_OVERRUN,
    input  wire logic [3:0]                 I_OVR_CLR
);
    logic [23:0] cnt;     // Cycles since port a took its byte
    logic [19:0] div;     // Divisor latched with that byte
    logic [7:0]  byte_l;  // Byte port a is sending
    wire  logic [23:0] bit_idx = cnt / 24'(div);  // Bit slot now on the line
    wire  logic exp_line = (bit_idx == 24'h0) ? 1'b0 :
                           (bit_idx >= 24'h9) ? 1'b1 : byte_l[3'(bit_idx - 24'h1)];

    // Frame timer and divisor, latched per accepted byte
    always_ff @(posedge I_MCLK or negedge I_ARST_N) begin
        if (!I_ARST_N) begin
            cnt <= 24'h0;
            div <= 20'h1;
            byte_l <= 8'h0;
        end else if (O_TX_READY[1] && I_TX_REQ[1].valid) begin
            cnt <= 24'h0;
            div <= I_BAUD_DIV[1];
            byte_l <= I_TX_REQ[1].data;
        end else if (!O_TX_READY[1]) begin
            cnt <= cnt + 24'h1;
        end
    end

    default clocking @(posedge I_MCLK); endclocking
    default disable iff (!I_ARST_N);

    sequence s_take_a;
        O_TX_READY[1] && I_TX_REQ[1].valid;
    endsequence
    sequence s_take_ldr;
        O_LDR_TX_READY && I_LDR_TX.valid;
    endsequence

    a_idle_line_high: assert property ((O_LDR_TX_READY || O_TX_READY[0]) |-> O_PRIMARY_SERIAL_OUT)
        else $error("primary line low while idle");
    a_ldr_start_low: assert property (s_take_ldr |=> !O_PRIMARY_SERIAL_OUT && !O_LDR_TX_READY)
        else $error("loader start bit not low");
    a_tx_busy_hold: assert property (s_take_a |=> !O_TX_READY[1] [*8])
        else $error("port a ready inside a frame");
    a_frame_bits: assert property (!O_TX_READY[1] |-> O_GPIO_OUT[I_TX_PIN_SEL[0]] == exp_line)
        else $error("port a frame bit wrong");
    a_frame_len: assert property ($rose(O_TX_READY[1]) |-> cnt == 24'(div) * 24'd10)
        else $error("port a frame not ten bits");
    a_ldr_gated: assert property ((O_LDR_RX.valid || O_LDR_RX.ferr) |-> !$past(I_PROG_RUN))
        else $error("loader got a user byte");
    a_user_gated: assert property (O_RX[0].valid |-> $past(I_PROG_RUN))
        else $error("user got a loader byte");
    a_ferr_no_data: assert property ((O_RX[0].ferr || O_LDR_RX.ferr) |-> !O_RX[0].valid && !O_LDR_RX.valid)
        else $error("framing error with data");
    a_oe_legal_pin: assert property ((O_GPIO_OE & ~`QSP_TX_PIN_MASK) == 16'h0)
        else $error("transmit on illegal pin");
    a_ovr_when_full: assert property ($rose(O_OVERRUN[2]) |-> $past(O_BUF_LEVEL[2]) == `QSP_BUF_FULL)
        else $error("overrun with room left");
    a_ovr_sticky: assert property (O_OVERRUN[2] && !I_OVR_CLR[2] |=> O_OVERRUN[2])
        else $error("overrun lost without clear");
endmodule : qsp_top_chk

// ==== tb/qsp_host_mdl.sv ====
// Behavioural serial host on the far side of the primary port
`timescale 1ns/1ps
module qsp_host_mdl #(
    parameter int DIV = 167  // Clocks per bit
) (
    input  wire logic i_clk,
    input  wire logic i_line,  // Device transmit line
    output logic      o_line   // Device receive line
);
    initial o_line = 1'b1;  // Idle high between frames

    // One frame; a low stop bit makes a framing fault
    task automatic send(input logic [7:0] d, input logic stop);
        logic [9:0] f;
        f = {stop, d, 1'b0};
        @(posedge i_clk);
        for (int i = 0; i < 10; i++) begin
            #1 o_line = f[i];
            repeat (DIV) @(posedge i_clk);
        end
        #1 o_line = 1'b1;
    endtask : send

    // Bounded start wait, then mid-bit samples
    task automatic recv(output logic [7:0] d, output logic stop, output logic ok);
        int n;
        n = 0;
        d = 8'h0;
        while (i_line !== 1'b0 && n < 20 * DIV) begin
            @(posedge i_clk);
            n++;
        end
        ok = (n < 20 * DIV);
        repeat (DIV / 2) @(posedge i_clk);
        for (int i = 0; i < 8; i++) begin
            repeat (DIV) @(posedge i_clk);
            d[i] = i_line;
        end
        repeat (DIV) @(posedge i_clk);
        stop = i_line;
    endtask : recv
endmodule : qsp_host_mdl

// ==== tb/tb_top.sv ====
// Self-checking bench for the quad serial port block
`timescale 1ns/1ps
module tb_top;
    localparam int DIV = 167;  // Fastest legal divisor, short run
    logic                     mclk = 1'b0;
    logic                     arst_n = 1'b0;
    logic                     prog_run = 1'b0;
    logic [3:0]               buf_mode = 4'h0;
    logic [3:0]               pop = 4'h0;
    logic [3:0]               ovr_clr = 4'h0;
    logic [3:0][19:0]         baud = {4{20'(DIV)}};
    qsp_pkg::qsp_byte_t       ldr_tx = '0;
    qsp_pkg::qsp_byte_t [3:0] tx_req = '0;
    qsp_pkg::qsp_rx_t         ldr_rx;
    qsp_pkg::qsp_rx_t [3:0]   rx;
    wire logic                host_out;
    wire logic                dev_out;
    wire logic                ldr_ready;
    wire logic [15:0]         gpio_out;
    wire logic [15:0]         gpio_oe;
    wire logic [15:0]         gpio_in = (gpio_oe & gpio_out) | ~gpio_oe;  // Pull-ups elsewhere
    wire logic [3:0]          tx_ready;
    wire logic [3:0]          buf_valid;
    wire logic [3:0]          overrun;
    wire logic [3:0][7:0]     buf_data;
    wire logic [3:0][2:0]     buf_level;
    int n_errors = 0;
    int n_compared = 0;
    int ldr_n, usr_n, fe_n;  // Receive pulses since last cleared
    logic [7:0] ldr_d, usr_d, b[5];
    logic [31:0] seed = 32'hac25;

    always #5 mclk = ~mclk;

    // Port a sends on pin 3 to ports b and c; port c asks for illegal pin 0
    qsp_top qsp_top_inst (.I_MCLK(mclk), .I_ARST_N(arst_n), .I_PRIMARY_SERIAL_IN(host_out),
        .O_PRIMARY_SERIAL_OUT(dev_out), .I_GPIO_IN(gpio_in), .O_GPIO_OUT(gpio_out),
        .O_GPIO_OE(gpio_oe), .I_TX_PIN_SEL({4'h0, 4'h0, 4'h3}), .I_TX_PIN_EN(3'b101),
        .I_RX_PIN_SEL({4'h3, 4'h3, 4'h0}), .I_RX_PIN_EN(3'b110), .I_PROG_RUN(prog_run),
        .I_LDR_TX(ldr_tx), .O_LDR_TX_READY(ldr_ready), .O_LDR_RX(ldr_rx), .I_BAUD_DIV(baud),
        .I_BUF_MODE(buf_mode), .I_TX_REQ(tx_req), .O_TX_READY(tx_ready), .O_RX(rx),
        .I_RX_POP(pop), .O_BUF_DATA(buf_data), .O_BUF_VALID(buf_valid),
        .O_BUF_LEVEL(buf_level), .O_OVERRUN(overrun), .I_OVR_CLR(ovr_clr));

    qsp_host_mdl #(.DIV(DIV)) qsp_host_mdl_inst (.i_clk(mclk), .i_line(dev_out),
        .o_line(host_out));

    // Count primary port receive pulses
    always @(posedge mclk) begin
        if (ldr_rx.valid === 1'b1) begin ldr_n++; ldr_d = ldr_rx.data; end
        if (rx[0].valid === 1'b1) begin usr_n++; usr_d = rx[0].data; end
        if (rx[0].ferr === 1'b1) fe_n++;
    end

    function automatic logic [7:0] rnd();
        seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
        return seed[7:0];
    endfunction : rnd

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_errors++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic print_verdict();
        $display("compared %0d, mismatches %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : print_verdict

    // Offer a byte to port p (4 = loader), held until taken
    task automatic dev_send(input int p, input logic [7:0] d);
        int n;
        n = 0;
        @(posedge mclk);
        #1 if (p == 4) ldr_tx = {1'b1, d};
        else tx_req[p] = {1'b1, d};
        while ((p == 4 ? ldr_ready : tx_ready[p]) !== 1'b1 && n < 20 * DIV) begin
            @(posedge mclk);
            #1 n++;
        end
        check(n < 20 * DIV, 1);
        @(posedge mclk);
        #1 ldr_tx = '0;
        tx_req = '0;
    endtask : dev_send

    // Both directions of the primary port at once
    task automatic duplex(input int p, input logic [7:0] din, input logic [7:0] dout);
        logic [7:0] got;
        logic stop, ok;
        ldr_n = 0;
        usr_n = 0;
        fork
            qsp_host_mdl_inst.send(din, 1'b1);
            dev_send(p, dout);
            qsp_host_mdl_inst.recv(got, stop, ok);
        join
        repeat (4) @(posedge mclk);
        #1 check({ok, stop, got}, {2'b11, dout});
        check(p == 4 ? {ldr_n[23:0], ldr_d} : {usr_n[23:0], usr_d}, {24'h1, din});
        check(p == 4 ? usr_n : ldr_n, 0);
    endtask : duplex

    initial begin
        repeat (40000) @(posedge mclk);
        n_errors++;
        $display("run stalled");
        print_verdict();
    end

    initial begin
        repeat (5) @(posedge mclk);
        #1 arst_n = 1'b1;
        check({dev_out, ldr_ready, tx_ready, buf_valid, overrun}, 14'h3e00);
        check(gpio_oe, 16'h0008);
        $display("test reset levels done");
        duplex(4, 8'h00, 8'hff);
        duplex(4, rnd(), rnd());
        check(tx_ready[0], 0);
        $display("test loader duplex done");
        prog_run = 1'b1;
        duplex(0, 8'h80, 8'h01);
        duplex(0, rnd(), rnd());
        $display("test user duplex done");
        fe_n = 0;
        usr_n = 0;
        qsp_host_mdl_inst.send(rnd(), 1'b0);
        repeat (4) @(posedge mclk);
        check({fe_n[15:0], usr_n[15:0]}, {16'h1, 16'h0});
        duplex(0, rnd(), rnd());
        $display("test framing error done");
        buf_mode = 4'h4;
        for (int i = 0; i < 5; i++) begin
            b[i] = rnd();
            dev_send(1, b[i]);
        end
        for (int n = 0; n < 12 * DIV && overrun[2] !== 1'b1; n++) @(posedge mclk);
        #1 check({overrun[2], buf_level[2], rx[3].data}, {4'hc, b[4]});
        for (int i = 0; i < 4; i++) begin
            check(buf_data[2], b[i]);
            pop[2] = 1'b1;
            @(posedge mclk);
            #1 pop[2] = 1'b0;
            @(posedge mclk);
            #1;
        end
        ovr_clr[2] = 1'b1;
        @(posedge mclk);
        #1 ovr_clr[2] = 1'b0;
        check({buf_valid[2], overrun[2]}, 0);
        $display("test buffered loopback done");
        dev_send(1, 8'h5a);
        repeat (DIV) @(posedge mclk);
        #1 arst_n = 1'b0;
        repeat (201) @(posedge mclk); // Over two microseconds low
        check({tx_ready, gpio_out[3], overrun}, 9'h1f0);
        #1 arst_n = 1'b1;
        $display("test mid-run reset done");
        print_verdict();
    end
endmodule : tb_top

bind qsp_top qsp_top_chk qsp_top_chk_inst (.I_MCLK, .I_ARST_N, .O_PRIMARY_SERIAL_OUT,
    .O_GPIO_OUT, .O_GPIO_OE, .I_TX_PIN_SEL, .I_PROG_RUN, .I_LDR_TX, .O_LDR_TX_READY,
    .O_LDR_RX, .I_BAUD_DIV, .I_TX_REQ, .O_TX_READY, .O_RX, .O_BUF_LEVEL, .O_OVERRUN,
    .I_OVR_CLR);
